// ===== verilog/charger_regs_pkg.sv
package charger_regs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_VOLTAGE = 8'h05;
  localparam logic [7:0] OFS_STATE = 8'h06;
  localparam logic [7:0] OFS_BUCK = 8'h07;

  localparam logic [7:0] TIMING_RST = 8'h4C;
  localparam logic [7:0] VOLTAGE_RST = 8'h41;
  localparam logic [7:0] BUCK_RST = 8'h29;
  localparam logic [7:0] TIMING_WMASK = 8'hEE;
  localparam logic [7:0] VOLTAGE_WMASK = 8'hFE;

  // ==========================================================
  // field positions
  localparam int TMR_HI = 7;
  localparam int TMR_LO = 6;
  localparam int PRE_BIT = 5;
  localparam int NTC_BIT = 3;
  localparam int PATH_BIT = 2;
  localparam int CMPEN_BIT = 1;
  localparam int CHV_HI = 7;
  localparam int CHV_LO = 5;
  localparam int SHIFT_HI = 4;
  localparam int SHIFT_LO = 3;
  localparam int CMPTH_HI = 2;
  localparam int CMPTH_LO = 1;
  localparam int KEEP_BIT = 7;
  localparam int DISCH_BIT = 6;

  // ==========================================================
  // decoded values
  localparam logic [8:0] TO_4H = 9'd240;
  localparam logic [8:0] TO_5H = 9'd300;
  localparam logic [8:0] TO_6H = 9'd360;
  localparam logic [8:0] TO_8H = 9'd480;
  localparam logic [5:0] PRE_SHORT = 6'd30;
  localparam logic [5:0] PRE_LONG = 6'd60;
  localparam logic [12:0] CHV_BASE_MV = 13'd4150;
  localparam logic [12:0] CHV_STEP_MV = 13'd25;
  localparam logic [5:0] COLD_BASE = 6'd0;
  localparam logic [5:0] HOT_BASE = 6'd45;
  localparam logic [5:0] SHIFT_STEP = 6'd5;
  localparam logic [11:0] CMP_BASE_MV = 12'd2200;
  localparam logic [11:0] CMP_STEP_MV = 12'd100;
  localparam logic [19:0] STEP_LIMIT_PCT = 20'd8;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK = 6'h04,
    S_WDATA = 6'h08,
    S_RDATA = 6'h10,
    S_RACK = 6'h20
  } i2c_state_t;

  // buck code to millivolts: 25 mV, then 50 mV, then 100 mV steps
  function automatic logic [11:0] buck_mv(input logic [5:0] c);
    logic [11:0] cc;
    cc = {6'h00, c};
    if (c < 6'd32) begin
      buck_mv = 12'd800 + 12'd25 * cc;
    end else if (c < 6'd60) begin
      buck_mv = 12'd1600 + 12'd50 * (cc - 12'd32);
    end else begin
      buck_mv = 12'd3000 + 12'd100 * (cc - 12'd60);
    end
  endfunction

endpackage

// ===== verilog/charger_buck_config_regs.sv
`timescale 1ns/1ps
// Contract
// - bits 7:6 pick charge timeout 4h, 5h, 6h or 8h.
// - bit 5 picks precharge timeout, 30 or 60 minutes.
// - bit 3 picks thermistor, 100k at 7.5 uA or 10k at 75 uA.
// - bit 2 picks path threshold, battery plus 100 mV or fixed 4.3 V.
// - bit 1 enables cell comparator; cleared disables it and its interrupt.
// - bits 7:5 pick charge voltage 4.15 V plus 25 mV per code.
// - bits 4:3 shift cold/hot limits from 0/45 by 5 degrees per code.
// - bits 2:1 set comparator threshold 2.2 V plus 0.1 V per code.
// - bit 0 reads one when cell below threshold or comparator disabled.
// - state register shows one flag per charger state, bit 7 down.
// - bit 7 keeps buck on when hold pin low and button released.
// - bit 6 discharges buck output while buck is disabled.
// - bits 5:0 hold buck voltage code, 0.800 V base, 25 mV steps below code 32, then 50 mV, then 100 mV from code 60.
// - too large upward step trips power good and forces device reset.
// - external divider variants store and read code; only the step trip uses it, buck voltage output stays zero.
// - undervoltage lockout or device reset reloads all defaults.
module charger_buck_config_regs
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary bus address
  parameter bit EXT_DIVIDER = 1'b0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic undervoltage_lockout_in,
  input wire logic device_reset_in,
  input wire logic cell_below_in,
  input wire logic [7:0] chg_state_in,
  input wire logic hold_pin_in,
  input wire logic pushbutton_in_n,
  output logic [8:0] charge_timeout_sel_out,
  output logic [5:0] precharge_timeout_sel_out,
  output logic thermistor_type_sel_out,
  output logic path_threshold_sel_out,
  output logic comparator_en_out,
  output logic [12:0] charge_voltage_sel_out,
  output logic [5:0] cold_limit_out,
  output logic [5:0] hot_limit_out,
  output logic [11:0] comparator_threshold_out,
  output logic comparator_irq_en_out,
  output logic buck_enable_out,
  output logic buck_discharge_out,
  output logic [11:0] buck_voltage_out,
  output logic reset_request_out
);
  import charger_regs_pkg::*;
  // ==========================================================
  // reset release
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end
  // ==========================================================
  // state
  typedef struct packed {
    i2c_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ptr_ok;
    logic [7:0] ptr;
    logic drive;
    logic [7:0] timing;
    logic [6:0] volt;
    logic [7:0] buck;
    logic [7:0] flags;
    logic [8:0] chg_to;
    logic [5:0] pre_to;
    logic thermistor_type_sel;
    logic path;
    logic cmp_en;
    logic [12:0] chg_mv;
    logic [5:0] cold;
    logic [5:0] hot;
    logic [11:0] cmp_mv;
    logic cmp_out;
    logic buck_on;
    logic disch;
    logic [11:0] buck_mv_q;
    logic reset_req;
  } regs_t;
  regs_t r;
  regs_t n;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic wr_en;
  logic [7:0] wr_val;
  logic [7:0] rd_val;
  logic [11:0] old_mv;
  logic [11:0] new_mv;
  logic too_big;
  always_comb begin
    n = r;
    wr_en = 1'b0;
    wr_val = r.sh;
    n.scl_q = scl_in;
    n.sda_q = sda_in;
    n.reset_req = 1'b0;
    rise = scl_in && !r.scl_q;
    fall = !scl_in && r.scl_q;
    start_c = scl_in && r.scl_q && r.sda_q && !sda_in;
    stop_c = scl_in && r.scl_q && !r.sda_q && sda_in;
    case (r.ptr)
      OFS_TIMING: rd_val = r.timing;
      OFS_VOLTAGE: rd_val = {r.volt, r.cmp_out};
      OFS_STATE: rd_val = r.flags;
      OFS_BUCK: rd_val = r.buck;
      default: rd_val = 8'h00;
    endcase
    // ========================================================
    // serial slave
    if (start_c) begin
      n.st = S_ADDR;
      n.cnt = 4'h0;
      n.ptr_ok = 1'b0;
      n.drive = 1'b0;
    end else if (stop_c) begin
      n.st = S_IDLE;
      n.drive = 1'b0;
    end else begin
      case (r.st)
        S_IDLE: n.drive = 1'b0;
        S_ADDR, S_WDATA: begin
          if (rise && r.cnt != 4'h8) begin
            n.sh = {r.sh[6:0], sda_in};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == 4'h8) begin
            n.cnt = 4'h0;
            n.drive = 1'b1;
            n.st = S_ACK;
            if (r.st == S_ADDR) begin
              n.rw = r.sh[0];
              if (r.sh[7:1] != DEV_ADDR) begin
                n.drive = 1'b0;
                n.st = S_IDLE;
              end
            end else if (!r.ptr_ok) begin
              n.ptr = r.sh;
              n.ptr_ok = 1'b1;
            end else begin
              wr_en = 1'b1;
              n.ptr = r.ptr + 8'h01;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            if (r.rw) begin
              n.sh = {rd_val[6:0], 1'b0};
              n.drive = !rd_val[7];
              n.cnt = 4'h1;
              n.ptr = r.ptr + 8'h01;
              n.st = S_RDATA;
            end else begin
              n.drive = 1'b0;
              n.st = S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (fall) begin
            if (r.cnt == 4'h8) begin
              n.drive = 1'b0;
              n.st = S_RACK;
            end else begin
              n.drive = !r.sh[7];
              n.sh = {r.sh[6:0], 1'b0};
              n.cnt = r.cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            if (sda_in) begin
              n.st = S_IDLE;
            end else begin
              n.st = S_ACK;
            end
          end
        end
        default: begin
          n.st = S_IDLE;
          n.drive = 1'b0;
        end
      endcase
    end
    // ========================================================
    // register writes
    old_mv = buck_mv(r.buck[5:0]);
    new_mv = buck_mv(wr_val[5:0]);
    // upward steps over 8 percent of the old voltage trip; the check mirrors the power good trip
    too_big = (new_mv > old_mv) &&
      ((20'(new_mv - old_mv) * 20'd100) > (20'(old_mv) * STEP_LIMIT_PCT));
    if (wr_en) begin
      case (r.ptr)
        OFS_TIMING: n.timing = wr_val & TIMING_WMASK;
        OFS_VOLTAGE: n.volt = wr_val[7:1];
        OFS_BUCK: begin
          n.buck = wr_val;
          if (too_big) begin
            n.reset_req = 1'b1;
          end
        end
        default: n.timing = r.timing;
      endcase
    end
    if (undervoltage_lockout_in || device_reset_in || n.reset_req) begin
      n.timing = TIMING_RST;
      n.volt = VOLTAGE_RST[7:1];
      n.buck = BUCK_RST;
    end
    // ========================================================
    // decoded controls
    // safety timeout decode
    case (n.timing[TMR_HI:TMR_LO])
      2'b00: n.chg_to = TO_4H;
      2'b01: n.chg_to = TO_5H;
      2'b10: n.chg_to = TO_6H;
      default: n.chg_to = TO_8H;
    endcase
    n.pre_to = n.timing[PRE_BIT] ? PRE_LONG : PRE_SHORT;
    n.thermistor_type_sel = n.timing[NTC_BIT];
    n.path = n.timing[PATH_BIT];
    n.cmp_en = n.timing[CMPEN_BIT];
    n.chg_mv = CHV_BASE_MV + CHV_STEP_MV * {10'h000, n.volt[CHV_HI-1:CHV_LO-1]};
    n.cold = COLD_BASE + SHIFT_STEP * {4'h0, n.volt[SHIFT_HI-1:SHIFT_LO-1]};
    n.hot = HOT_BASE + SHIFT_STEP * {4'h0, n.volt[SHIFT_HI-1:SHIFT_LO-1]};
    n.cmp_mv = CMP_BASE_MV + CMP_STEP_MV * {10'h000, n.volt[CMPTH_HI-1:CMPTH_LO-1]};
    n.cmp_out = !n.cmp_en || cell_below_in;
    n.flags = chg_state_in;
    n.buck_on = hold_pin_in || !pushbutton_in_n || n.buck[KEEP_BIT];
    n.disch = !n.buck_on && n.buck[DISCH_BIT];
    n.buck_mv_q = EXT_DIVIDER ? 12'h000 : buck_mv(n.buck[5:0]);
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= S_IDLE;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.timing <= TIMING_RST;
      r.volt <= VOLTAGE_RST[7:1];
      r.buck <= BUCK_RST;
      r.chg_to <= TO_5H;
      r.pre_to <= PRE_SHORT;
      r.thermistor_type_sel <= 1'b1;
      r.path <= 1'b1;
      r.chg_mv <= CHV_BASE_MV + CHV_STEP_MV * 13'd2;
      r.hot <= HOT_BASE;
      r.cmp_mv <= CMP_BASE_MV;
      r.cmp_out <= 1'b1;
    end else begin
      r <= n;
    end
  end
  // ==========================================================
  // outputs; sda only ever pulls low
  assign sda_out = 1'b0 & r.drive;
  assign sda_oe_n_out = !r.drive;
  assign charge_timeout_sel_out = r.chg_to;
  assign precharge_timeout_sel_out = r.pre_to;
  assign thermistor_type_sel_out = r.thermistor_type_sel;
  assign path_threshold_sel_out = r.path;
  assign comparator_en_out = r.cmp_en;
  assign comparator_irq_en_out = r.cmp_en;
  assign charge_voltage_sel_out = r.chg_mv;
  assign cold_limit_out = r.cold;
  assign hot_limit_out = r.hot;
  assign comparator_threshold_out = r.cmp_mv;
  assign buck_enable_out = r.buck_on;
  assign buck_discharge_out = r.disch;
  assign buck_voltage_out = r.buck_mv_q;
  assign reset_request_out = r.reset_req;
  // ==========================================================
  // checks
  property p_timeout;
    @(posedge clk_in) disable iff (!rst_n)
    (r.timing[TMR_HI:TMR_LO] == 2'b11) |-> (charge_timeout_sel_out == 9'd480);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout decode wrong");
  property p_pre;
    @(posedge clk_in) disable iff (!rst_n)
    precharge_timeout_sel_out == (r.timing[PRE_BIT] ? 6'd60 : 6'd30);
  endproperty
  a_pre: assert property (p_pre) else $error("precharge decode wrong");
  property p_chgv;
    @(posedge clk_in) disable iff (!rst_n)
    (r.volt[6:4] == 3'b111) |-> (charge_voltage_sel_out == 13'd4325);
  endproperty
  a_chgv: assert property (p_chgv) else $error("charge voltage wrong");
  property p_hot;
    @(posedge clk_in) disable iff (!rst_n)
    (hot_limit_out - cold_limit_out) == 6'd45;
  endproperty
  a_hot: assert property (p_hot) else $error("window width wrong");
  property p_cmp;
    @(posedge clk_in) disable iff (!rst_n)
    !r.timing[CMPEN_BIT] |-> (r.cmp_out && comparator_irq_en_out == 1'b0);
  endproperty
  a_cmp: assert property (p_cmp) else $error("disabled comparator not reported");
  property p_flags;
    @(posedge clk_in) disable iff (!rst_n)
    ##1 r.flags == $past(chg_state_in);
  endproperty
  a_flags: assert property (p_flags) else $error("state flags stale");
  property p_buck_off;
    @(posedge clk_in) disable iff (!rst_n)
    (!hold_pin_in && pushbutton_in_n && !n.buck[KEEP_BIT] && n.buck[DISCH_BIT])
      |=> (!buck_enable_out && buck_discharge_out);
  endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck not off");
  property p_defaults;
    @(posedge clk_in) disable iff (!rst_n)
    undervoltage_lockout_in |=> (r.timing == TIMING_RST && r.buck == BUCK_RST);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not reloaded");
  property p_reserved;
    @(posedge clk_in) disable iff (!rst_n)
    r.timing[4] == 1'b0 && r.timing[0] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_trip;
    @(posedge clk_in) disable iff (!rst_n)
    reset_request_out |-> (r.buck == BUCK_RST) ##1 !reset_request_out;
  endproperty
  a_trip: assert property (p_trip) else $error("trip without reload");
  c_write: cover property (@(posedge clk_in) disable iff (!rst_n) wr_en);
  c_read: cover property (@(posedge clk_in) disable iff (!rst_n) r.st == S_RDATA);
  c_trip: cover property (@(posedge clk_in) disable iff (!rst_n) reset_request_out);
endmodule

// ===== bench/i2c_host_model.sv
`timescale 1ns/1ps
// ==========================================
// serial host: drives the clock line, pulls data low, reads the wire
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // quarter bit; long enough for the device's input synchronisers
  task automatic q();
    repeat (6) @(negedge clk_in);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b0;
    q();
  endtask
  // data changes only while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ak, k);
  endtask
  // upward steps are limited by the codes the caller picks
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    xfer(d, 1'b1, r, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, d, k);
    xfer(a, 1'b1, d, k);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, d, k);
    xfer(8'hFF, 1'b1, d, k);
    stop();
  endtask
endmodule

// ===== bench/tb_charger_buck_config_regs.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    end \
  end
// ==========================================
// bench top
module tb_charger_buck_config_regs;
  import charger_regs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic undervoltage_lockout = 1'b0;
  logic drst = 1'b0;
  logic below = 1'b0;
  logic [7:0] state = 8'h00;
  logic hold = 1'b0;
  logic pb_n = 1'b1;
  logic scl, sda_low, sda_oe_n, sda_o, tsel, pth, cen, cirq, ben, bdis, rreq, nak;
  wire sda;
  logic [8:0] cto;
  logic [5:0] pto, cold, hot;
  logic [12:0] chv;
  logic [11:0] cth, bmv;
  logic [11:0] bmv_div;
  logic oe_div_n;
  logic [7:0] d;
  int n_errors = 0;
  int total_checks = 0;
  int n_rreq = 0;
  // pull-up: low when the host or either device pulls
  assign sda = ~(sda_low | ~sda_oe_n | ~oe_div_n);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (rreq === 1'b1) n_rreq++;
  end
  charger_buck_config_regs dut_u (.clk_in(clk), .resetn_in(resetn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .undervoltage_lockout_in(undervoltage_lockout),
    .device_reset_in(drst), .cell_below_in(below), .chg_state_in(state), .hold_pin_in(hold),
    .pushbutton_in_n(pb_n), .charge_timeout_sel_out(cto), .precharge_timeout_sel_out(pto),
    .thermistor_type_sel_out(tsel), .path_threshold_sel_out(pth), .comparator_en_out(cen),
    .charge_voltage_sel_out(chv), .cold_limit_out(cold), .hot_limit_out(hot),
    .comparator_threshold_out(cth), .comparator_irq_en_out(cirq), .buck_enable_out(ben),
    .buck_discharge_out(bdis), .buck_voltage_out(bmv), .reset_request_out(rreq));
  // divider variant shares the wire; it tracks dut_u, so readback proves it stores the code
  charger_buck_config_regs #(.EXT_DIVIDER(1'b1)) dut_div_u (.clk_in(clk), .resetn_in(resetn),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n_out(oe_div_n),
    .undervoltage_lockout_in(undervoltage_lockout), .device_reset_in(drst), .cell_below_in(below),
    .chg_state_in(state), .hold_pin_in(hold), .pushbutton_in_n(pb_n),
    .charge_timeout_sel_out(), .precharge_timeout_sel_out(), .thermistor_type_sel_out(),
    .path_threshold_sel_out(), .comparator_en_out(), .charge_voltage_sel_out(),
    .cold_limit_out(), .hot_limit_out(), .comparator_threshold_out(),
    .comparator_irq_en_out(), .buck_enable_out(), .buck_discharge_out(),
    .buck_voltage_out(bmv_div), .reset_request_out());
  i2c_host_model host_u (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  task automatic t_reset();
    host_u.rd(OFS_TIMING, d);
    `CHK("timing", TIMING_RST, d)
    host_u.rd(OFS_VOLTAGE, d);
    `CHK("voltage", VOLTAGE_RST, d)
    host_u.rd(OFS_BUCK, d);
    `CHK("buck", BUCK_RST, d)
    `CHK("timeout", 9'd300, cto)
    `CHK("chv", 13'd4200, chv)
    `CHK("buck mv", 12'd2050, bmv)
    `CHK("sda out", 1'b0, sda_o)
    $display("test reset done");
  endtask
  task automatic t_timing();
    logic [35:0] tbl;
    tbl = {9'd240, 9'd300, 9'd360, 9'd480};
    for (int i = 0; i < 4; i++) begin
      host_u.wr(OFS_TIMING, {i[1:0], 6'h3F}, nak);
      `CHK("ack", 1'b0, nak)
      `CHK("timeout", tbl[35 - 9 * i -: 9], cto)
      host_u.rd(OFS_TIMING, d);
      `CHK("timing rb", {i[1:0], 6'h2E}, d)
    end
    `CHK("pre", 6'd60, pto)
    `CHK("ntc", 1'b1, tsel)
    `CHK("path", 1'b1, pth)
    `CHK("cmp en", 2'b11, {cen, cirq})
    host_u.wr(OFS_TIMING, 8'h00, nak);
    `CHK("pre", 6'd30, pto)
    `CHK("ntc", 1'b0, tsel)
    `CHK("path", 1'b0, pth)
    `CHK("cmp en", 2'b00, {cen, cirq})
    $display("test timing done");
  endtask
  task automatic t_voltage();
    host_u.wr(OFS_VOLTAGE, 8'hFF, nak);
    host_u.rd(OFS_VOLTAGE, d);
    `CHK("cmp off", 8'hFF, d)
    `CHK("chv", 13'd4325, chv)
    `CHK("limits", {6'd15, 6'd60}, {cold, hot})
    `CHK("thr", 12'd2500, cth)
    host_u.wr(OFS_TIMING, 8'h02, nak);
    host_u.rd(OFS_VOLTAGE, d);
    `CHK("cmp above", 8'hFE, d)
    below = 1'b1;
    host_u.wr(OFS_VOLTAGE, 8'h00, nak);
    host_u.rd(OFS_VOLTAGE, d);
    `CHK("cmp below", 8'h01, d)
    `CHK("chv", 13'd4150, chv)
    `CHK("limits", {6'd0, 6'd45}, {cold, hot})
    `CHK("thr", 12'd2200, cth)
    $display("test voltage done");
  endtask
  task automatic t_state();
    for (int i = 0; i < 8; i++) begin
      state = 8'h80 >> i;
      host_u.rd(OFS_STATE, d);
      `CHK("state", 8'h80 >> i, d)
    end
    host_u.wr(OFS_STATE, 8'h00, nak);
    host_u.rd(OFS_STATE, d);
    `CHK("state ro", 8'h01, d)
    host_u.rd(8'h08, d);
    `CHK("unmapped", 8'h00, d)
    $display("test state done");
  endtask
  task automatic t_buck();
    host_u.wr(OFS_BUCK, 8'h4A, nak);
    `CHK("buck off", 2'b01, {ben, bdis})
    `CHK("buck mv", 12'd1050, bmv)
    `CHK("div mv", 12'h000, bmv_div)
    host_u.rd(OFS_BUCK, d);
    `CHK("div store", 8'h4A, d)
    pb_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("button on", 2'b10, {ben, bdis})
    pb_n = 1'b1;
    // small upward step, inside the limit
    host_u.wr(OFS_BUCK, 8'h8B, nak);
    `CHK("keep on", 2'b10, {ben, bdis})
    `CHK("buck mv", 12'd1075, bmv)
    `CHK("no trip", 0, n_rreq)
    host_u.wr(OFS_BUCK, 8'h3F, nak);
    `CHK("trip", 1, n_rreq)
    host_u.rd(OFS_BUCK, d);
    `CHK("trip reload", BUCK_RST, d)
    hold = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("hold on", 1'b1, ben)
    hold = 1'b0;
    $display("test buck done");
  endtask
  task automatic t_reload();
    for (int k = 0; k < 2; k++) begin
      host_u.wr(OFS_TIMING, 8'hEE, nak);
      undervoltage_lockout = (k == 0);
      drst = (k == 1);
      repeat (2) @(negedge clk);
      undervoltage_lockout = 1'b0;
      drst = 1'b0;
      host_u.rd(OFS_TIMING, d);
      `CHK("reload", TIMING_RST, d)
      `CHK("timeout", 9'd300, cto)
    end
    host_u.start();
    host_u.xfer({7'h2B, 1'b0}, 1'b1, d, nak);
    host_u.stop();
    `CHK("wrong addr nak", 1'b1, nak)
    $display("test reload done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_timing();
    t_voltage();
    t_state();
    t_buck();
    t_reload();
    final_report();
  end
  // about 40 register accesses of 17 to 23 us each, with margin
  initial begin
    #1500000;
    n_errors++;
    $display("[FAIL] watchdog exp done got timeout");
    final_report();
  end
endmodule
